// [i2cr_consts.svh]
/*
  Constants of the two-wire slave register port: addresses, register map, clock rates.
  Assumes inclusion by the package and the port module; definitions only.
*/
// Function
// - the receiving side acknowledges by holding SDA low through the ninth clock.
// - not-acknowledge is SDA released high through the ninth clock's high phase.
// - the device answers a fixed 7-bit address, C0/C2 write, C1/C3 read.
// - after START and a matching address the device acknowledges, then follows direction.
// - the first written byte loads the register pointer and is acknowledged.
// - data bytes arrive MSB first, are stored if the pointer is writable, then acknowledged; a stored byte meeting a full write FIFO is not acknowledged.
// - the pointer advances by one after each stored byte.
// - a write stays open until STOP or a repeated START.
// - read data leaves on SDA MSB first, one bit per SCL cycle.
// - master acknowledge advances pointer and continues; not-acknowledge ends data.
// - reading the status register clears the power-cycled flag, set at power-up.
// - transfers work at SCL up to 400 kHz, master drives SCL.
`ifndef I2CR_CONSTS_SVH
`define I2CR_CONSTS_SVH

`define I2CR_ADDR_BASE 7'h60
`define I2CR_ADDR_ALT 7'h61
`define I2CR_NUM_REGS 18
`define I2CR_REG_STATUS 8'h0C
`define I2CR_REG_VAS_STATUS 8'h0D
`define I2CR_STATUS_PWR_BIT 0
`define I2CR_STATUS_UNUSED 2'h3
`define I2CR_CLK_HZ 125000000
`define I2CR_SCL_MAX_HZ 400000

`endif

// [i2cr_pkg.sv]
/*
  Types of the two-wire slave register port.
  Assumes the constants header sits beside it.
*/
package i2cr_pkg;
  `include "i2cr_consts.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101
  } i2cr_state_e;

  // one register write toward the analog side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } i2cr_wr_s;

  // status inputs from the analog side
  typedef struct packed {
    logic [2:0] adc;
    logic [1:0] vcp;
    logic [7:0] vas;
  } i2cr_stat_s;
endpackage

// [i2cr_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module i2cr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= inc(wp);
      if (pop) rp <= inc(rp);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // i2cr_fifo

// [i2cr_port.sv]
/*
  Two-wire slave port giving a bus master byte access to the control and status registers.
  Assumes SDA/SCL arrive from pins, resolved outside from sda_oe; writes leave through a FIFO.
*/
`timescale 1ns/1ps
`include "i2cr_consts.svh"
module i2cr_port
  import i2cr_pkg::*;
#(
  parameter int NUM_REGS = `I2CR_NUM_REGS,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // configuration
  input wire logic addr_sel,
  // analog side
  input wire i2cr_stat_s stat,
  output logic [NUM_REGS*8-1:0] regs_flat,
  output logic wr_valid,
  input wire logic wr_ready,
  output i2cr_wr_s wr_data
);
  // ---------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  // sampled far below the 8 ns clock, so 400 kHz edges are resolved
  assign scl_rise = scl_sy[1] && !scl_d;
  assign scl_fall = !scl_sy[1] && scl_d;
  assign start_c = scl_sy[1] && scl_d && sda_d && !sda_sy[1];
  assign stop_c = scl_sy[1] && scl_d && !sda_d && sda_sy[1];

  // ---------------------------------------------------------------
  // address selection latched after reset release
  // ---------------------------------------------------------------
  logic sel_taken;
  logic sel;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_taken <= 1'b0;
      sel <= 1'b0;
    end else if (!sel_taken) begin
      sel_taken <= 1'b1;
      sel <= addr_sel;
    end
  end
  logic [6:0] my_addr;
  assign my_addr = sel ? `I2CR_ADDR_ALT : `I2CR_ADDR_BASE;

  // ---------------------------------------------------------------
  // register store
  // ---------------------------------------------------------------
  logic [7:0] regs [NUM_REGS];
  logic pwr_flag;

  function automatic logic is_ro(input logic [7:0] a);
    is_ro = (a == `I2CR_REG_STATUS) || (a == `I2CR_REG_VAS_STATUS) || (a >= 8'(NUM_REGS));
  endfunction

  function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic pf, input i2cr_stat_s s,
                                        input logic [7:0] r);
    if (a == `I2CR_REG_STATUS) rd_reg = {`I2CR_STATUS_UNUSED, s.adc, s.vcp, pf};
    else if (a == `I2CR_REG_VAS_STATUS) rd_reg = s.vas;
    else if (a >= 8'(NUM_REGS)) rd_reg = 8'h00;
    else rd_reg = r;
  endfunction

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  i2cr_state_e state;
  logic [7:0] shreg;
  logic [2:0] bitn;
  logic [7:0] ptr;
  logic is_read;
  logic ptr_phase;
  logic ack_drive;
  logic nack_pend;
  logic stall;
  logic fifo_in_ready;
  logic fifo_push;
  logic [7:0] ptr_idx_data;
  i2cr_wr_s fifo_in;

  assign ptr_idx_data = regs[ptr[4:0] < 5'(NUM_REGS) ? ptr[4:0] : 5'h0];

  // data byte complete on the eighth rising edge
  logic byte_done;
  assign byte_done = scl_rise && (bitn == 3'h7);

  // a data write that finds no room in the FIFO is not acknowledged and its record is dropped
  assign stall = (state == ST_ACK) && fifo_push && !fifo_in_ready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitn <= 3'h0;
      is_read <= 1'b0;
      ptr_phase <= 1'b0;
      ack_drive <= 1'b0;
      nack_pend <= 1'b0;
      fifo_push <= 1'b0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      ack_drive <= 1'b0;
      nack_pend <= 1'b0;
      fifo_push <= 1'b0;
    end else if (start_c) begin
      state <= ST_ADDR;
      bitn <= 3'h0;
      ack_drive <= 1'b0;
      nack_pend <= 1'b0;
      fifo_push <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          ack_drive <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_sy[1]};
            bitn <= bitn + 3'h1;
          end
          if (byte_done) begin
            if (shreg[6:0] == my_addr) begin
              is_read <= sda_sy[1];
              ptr_phase <= !sda_sy[1];
              state <= ST_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_sy[1]};
            bitn <= bitn + 3'h1;
          end
          if (byte_done) begin
            state <= ST_ACK;
            // pointer byte done: later bytes are data
            ptr_phase <= 1'b0;
            fifo_push <= !ptr_phase && !is_ro(ptr);
          end
        end
        ST_ACK: begin
          if (fifo_push && fifo_in_ready) fifo_push <= 1'b0;
          // drive low from the falling edge before the ninth pulse
          if (scl_fall && !ack_drive && !nack_pend) begin
            if (stall) begin
              // no room: release for the ninth pulse and drop the record
              nack_pend <= 1'b1;
              fifo_push <= 1'b0;
            end else begin
              ack_drive <= 1'b1;
            end
          end else if (scl_fall) begin
            ack_drive <= 1'b0;
            nack_pend <= 1'b0;
            bitn <= 3'h0;
            if (is_read) begin
              state <= ST_TX;
              shreg <= rd_reg(ptr, pwr_flag, stat, ptr_idx_data);
            end else begin
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bitn <= bitn + 3'h1;
            shreg <= {shreg[6:0], 1'b0};
            if (bitn == 3'h7) state <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_sy[1]) begin
            state <= ST_IDLE;
          end else if (scl_fall) begin
            // master acknowledged: next register leaves from this fall
            bitn <= 3'h0;
            state <= ST_TX;
            shreg <= rd_reg(ptr, pwr_flag, stat, ptr_idx_data);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register pointer and status flag
  // ---------------------------------------------------------------
  logic ptr_load;
  logic ptr_adv;
  logic status_rd;
  assign ptr_load = (state == ST_RX) && byte_done && ptr_phase;
  assign ptr_adv = ((state == ST_RX) && byte_done && !ptr_phase)
                 || ((state == ST_MACK) && scl_rise && !sda_sy[1]);
  // taken when the status byte is loaded for sending
  assign status_rd = (ptr == `I2CR_REG_STATUS) && scl_fall
                   && (((state == ST_ACK) && is_read && ack_drive) || (state == ST_MACK));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr <= 8'h00;
    end else if (ptr_load) begin
      ptr <= {shreg[6:0], sda_sy[1]};
    end else if (ptr_adv) begin
      ptr <= ptr + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_flag <= 1'b1;
    end else if (status_rd) begin
      pwr_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register write path and outgoing FIFO
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) regs[i] <= 8'h00;
      fifo_in <= '0;
    end else if ((state == ST_RX) && byte_done && !ptr_phase) begin
      fifo_in <= '{addr: ptr, data: {shreg[6:0], sda_sy[1]}};
      if (!is_ro(ptr)) regs[ptr[4:0]] <= {shreg[6:0], sda_sy[1]};
    end
  end

  i2cr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) regs_flat[i*8 +: 8] = regs[i];
  end

  // ---------------------------------------------------------------
  // open-drain SDA
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe <= 1'b0;
    end else begin
      // master not-acknowledge left to the master; data 1 is a release
      sda_oe <= ack_drive || ((state == ST_TX) && !shreg[7]);
    end
  end
  assign sda_out = 1'b0;
endmodule // i2cr_port

// [i2cr_port_props.sv]
/*
  Concurrent checks on the two-wire register port, seen from its ports only.
  Assumes the resolved SDA wire on sda_in and SCL periods far above the 2-flop sync lag.
*/
`timescale 1ns/1ps
module i2cr_port_props
  import i2cr_pkg::*;
#(
  parameter int NUM_REGS = 18,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_sel,
  // analog side
  input wire i2cr_stat_s stat,
  input wire logic [NUM_REGS*8-1:0] regs_flat,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire i2cr_wr_s wr_data
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  a_low_holds: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*8])
    else $error("sda low not held");
  a_start_quiet: assert property (scl_in && $past(scl_in) && $fell(sda_in) && !$past(sda_oe) |=> !sda_oe [*8])
    else $error("sda pulled right after start");
  a_stop_quiet: assert property (scl_in && $past(scl_in) && $rose(sda_in) |=> (!sda_oe throughout scl_in [*4]))
    else $error("sda pulled after stop");
  a_hold_record: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("record lost while stalled");
  a_record_in_map: assert property (wr_valid |-> wr_data.addr < NUM_REGS && wr_data.addr != 8'h0C && wr_data.addr != 8'h0D)
    else $error("record for read-only or unmapped place");
  a_store_scl_high: assert property ($changed(regs_flat) |-> scl_in)
    else $error("register stored outside eighth bit");
  a_push_scl_high: assert property ($rose(wr_valid) |-> $past(scl_in, 2))
    else $error("record pushed outside eighth bit");

  c_ack: cover property ($rose(sda_oe));
  c_stall: cover property (wr_valid && !wr_ready);
  c_pop: cover property (wr_valid && wr_ready);
endmodule // i2cr_port_props

bind i2cr_port i2cr_port_props #(.NUM_REGS(NUM_REGS), .FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk(clk), .nrst(nrst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .stat(stat),
  .regs_flat(regs_flat), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));

// [i2cr_master_model.sv]
/*
  Behavioural two-wire bus master: drives SCL, pulls SDA low.
  Assumes the bench resolves SDA with a pull-up and calls the tasks.
*/
`timescale 1ns/1ps
module i2cr_master_model (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int q = 20;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wq();
    repeat (q) @(posedge clk);
  endtask
  // start or repeated start; master alone makes scl
  task automatic start();
    sda_low <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  // stop closes every cycle
  task automatic stop();
    sda_low <= 1'b1;
    wq();
    scl <= 1'b1;
    wq();
    sda_low <= 1'b0;
    wq();
  endtask
  // sda set while scl low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    wq();
    scl <= 1'b1;
    wq();
    r = sda;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  // msb first; ninth released to hear ack, or low as master ack
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(nine, a);
  endtask
endmodule // i2cr_master_model

// [test_i2cr_port.sv]
/*
  Self-checking bench of the two-wire register port.
  Assumes the master model and bound checker beside it.
*/
`timescale 1ns/1ps
module test_i2cr_port;
  import i2cr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic addr_sel = 1'b0;
  logic wr_ready = 1'b1;
  i2cr_stat_s stat = '{adc: 3'h5, vcp: 2'h2, vas: 8'hA7};
  logic scl, sda_low, sda_out, sda_oe, wr_valid;
  wire sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  logic [18*8-1:0] regs_flat;
  i2cr_wr_s wr_data;
  i2cr_wr_s got_q[$];
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  i2cr_port #(.NUM_REGS(18), .FIFO_DEPTH(8)) u_dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .stat(stat), .regs_flat(regs_flat),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
  i2cr_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) got_q.push_back(wr_data);
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: ack %b want %b", $time, g, e);
    end
  endtask
  function automatic logic [7:0] dat(int i);
    return 8'hE1 ^ 8'(i * 29);
  endfunction
  task automatic reset_dut();
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic sbyte(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic a;
    m.xfer(d, 1'b1, r, a);
    chk1(~a, ea);
  endtask
  task automatic rbyte(input logic last, input logic [7:0] e);
    logic [7:0] r;
    logic a;
    m.xfer(8'hFF, last, r, a);
    chk8(r, e);
  endtask
  task automatic rd_start(input logic [7:0] p);
    m.start();
    sbyte(8'hC0, 1'b1);
    sbyte(p, 1'b1);
    m.start();
    sbyte(8'hC1, 1'b1);
  endtask
  task automatic drain(input int n);
    repeat (20) @(posedge clk);
    chk8(8'(got_q.size()), 8'(n));
  endtask

  task automatic t_write_stall();
    wr_ready <= 1'b0;
    m.start();
    sbyte(8'hC0, 1'b1);
    sbyte(8'h00, 1'b1);
    for (int i = 0; i < 8; i++) sbyte(dat(i), 1'b1);
    sbyte(8'h99, 1'b0);
    m.stop();
    for (int i = 0; i < 8; i++) chk8(regs_flat[i*8+:8], dat(i));
    wr_ready <= 1'b1;
    drain(8);
    for (int i = 0; i < 8; i++) chk8(got_q[i].addr, 8'(i));
    for (int i = 0; i < 8; i++) chk8(got_q[i].data, dat(i));
    got_q.delete();
  endtask
  task automatic t_read_back();
    rd_start(8'h00);
    for (int i = 0; i < 8; i++) rbyte(i == 7, dat(i));
    m.stop();
  endtask
  task automatic t_status();
    rd_start(8'h0C);
    rbyte(1'b0, {2'b11, stat.adc, stat.vcp, 1'b1});
    rbyte(1'b1, stat.vas);
    m.stop();
    rd_start(8'h0C);
    rbyte(1'b1, {2'b11, stat.adc, stat.vcp, 1'b0});
    m.stop();
  endtask
  task automatic t_readonly();
    m.start();
    sbyte(8'hC0, 1'b1);
    sbyte(8'h0B, 1'b1);
    sbyte(8'h5A, 1'b1);
    sbyte(8'h77, 1'b1);
    sbyte(8'h66, 1'b1);
    m.start();
    sbyte(8'hC0, 1'b1);
    sbyte(8'h11, 1'b1);
    sbyte(8'h3C, 1'b1);
    sbyte(8'hC5, 1'b1);
    m.stop();
    drain(2);
    chk8(got_q[0].addr, 8'h0B);
    chk8(got_q[1].addr, 8'h11);
    chk8(regs_flat[8'h0B*8+:8], 8'h5A);
    chk8(regs_flat[8'h0C*8+:8], 8'h00);
    chk8(regs_flat[8'h0D*8+:8], 8'h00);
    chk8(regs_flat[8'h11*8+:8], 8'h3C);
    got_q.delete();
  endtask
  task automatic t_address();
    m.q = 80;
    m.start();
    sbyte(8'hC4, 1'b0);
    m.stop();
    m.start();
    sbyte(8'hC2, 1'b0);
    m.stop();
    addr_sel <= 1'b1;
    reset_dut();
    chk8(regs_flat[7:0], 8'h00);
    m.start();
    sbyte(8'hC2, 1'b1);
    sbyte(8'h00, 1'b1);
    sbyte(8'h42, 1'b1);
    m.stop();
    chk8(regs_flat[7:0], 8'h42);
    m.start();
    sbyte(8'hC0, 1'b0);
    m.stop();
  endtask

  initial begin
    reset_dut();
    t_write_stall();
    t_read_back();
    t_status();
    t_readonly();
    t_address();
    complete_run();
  end
endmodule // test_i2cr_port
